// ### twis_pkg.sv
// Constants, register map and field layout of the timer, watchdog and interrupt block
package twis_pkg;

    // Register offsets on the plain register port
    localparam int unsigned ADDR_W        = 3;
    localparam logic [2:0]  OFS_MODE      = 3'h0;
    localparam logic [2:0]  OFS_COUNT     = 3'h1;
    localparam logic [2:0]  OFS_FLAG      = 3'h2;
    localparam logic [2:0]  OFS_MASK      = 3'h3;
    localparam logic [2:0]  OFS_PBEN      = 3'h4;
    localparam logic [2:0]  OFS_STATUS    = 3'h5;

    // Field positions of the timer0 mode register
    localparam int unsigned MODE_EXT_EDGE = 6;
    localparam int unsigned MODE_CLK_SRC  = 5;
    localparam int unsigned MODE_CLK_EDGE = 4;
    localparam int unsigned MODE_PSC_WDT  = 3;
    localparam int unsigned MODE_RATIO_HI = 2;

    // Bit positions in the flag and mask registers
    localparam int unsigned NUM_SRC       = 6;
    localparam int unsigned SRC_T0        = 0;
    localparam int unsigned SRC_T1        = 1;
    localparam int unsigned SRC_T2        = 2;
    localparam int unsigned SRC_PB        = 3;
    localparam int unsigned SRC_EXT       = 4;
    localparam int unsigned SRC_WDT       = 5;

    // Bit positions in the status register
    localparam int unsigned STAT_TO       = 4;
    localparam int unsigned STAT_PD       = 3;
    localparam int unsigned STAT_GIE      = 0;

    // Reset values
    localparam logic [7:0]  RST_MODE      = 8'h3F;
    localparam logic [7:0]  RST_PBEN      = 8'hFF;
    localparam logic [5:0]  RST_MASK      = 6'h00;

    // Interrupt vectors
    localparam logic [11:0] VEC_INT       = 12'h008;
    localparam logic [11:0] VEC_SWINT     = 12'h001;

    // Watchdog base period counted on the watchdog oscillator
    localparam int unsigned WDT_CNT_W     = 16;
    localparam int unsigned WDT_PERIOD_US = 18000;
    localparam int unsigned WDT_OSC_KHZ   = 32;
    localparam int unsigned WDT_BASE_TICKS = (WDT_PERIOD_US * WDT_OSC_KHZ) / 1000;

    // Synchroniser lanes: port B in 7:0, then external pins
    localparam int unsigned PIN_EXT_INT   = 8;
    localparam int unsigned PIN_T0_CLK    = 9;
    localparam int unsigned PIN_WDT_OSC   = 10;
    localparam int unsigned PIN_W         = 11;

    // Core run state, one-hot
    typedef enum logic [1:0] {
        TWIS_RUN   = 2'b01,
        TWIS_SLEEP = 2'b10
    } twis_state_e;

endpackage

// ### twis_core.sv
// Timer0, watchdog, shared prescaler, interrupt flags and sleep control
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps

module twis_core
    import twis_pkg::*;
#(
    parameter logic [WDT_CNT_W-1:0] WDT_BASE = WDT_CNT_W'(WDT_BASE_TICKS)
)(
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_we_i,
    input  wire logic                reg_re_i,
    output logic      [7:0]          reg_rdata_o,
    input  wire logic                watchdog_clear_instr_i,
    input  wire logic                global_int_enable_instr_i,
    input  wire logic                global_int_disable_instr_i,
    input  wire logic                return_from_isr_instr_i,
    input  wire logic                sw_int_instr_i,
    input  wire logic                sleep_instr_i,
    input  wire logic                timer1_wrap_i,
    input  wire logic                timer2_wrap_i,
    input  wire logic                watchdog_action_select_i,
    input  wire logic                watchdog_osc_i,
    input  wire logic                timer0_ext_clock_pin_i,
    input  wire logic                ext_int_pin_i,
    input  wire logic [7:0]          portb_pin_i,
    input  wire logic [7:0]          portb_is_input_i,
    output logic                     int_take_o,
    output logic      [11:0]         int_vector_o,
    output logic                     wake_o,
    output logic                     wdt_reset_o,
    output logic                     osc_stop_o,
    output logic                     io_hold_o
);

    typedef struct packed {
        logic [PIN_W-1:0]     sync1;
        logic [PIN_W-1:0]     sync2;
        logic [PIN_W-1:0]     prev;
        twis_state_e          st;
        logic [7:0]           mode;
        logic [7:0]           count;
        logic [NUM_SRC-1:0]   flags;
        logic [NUM_SRC-1:0]   mask;
        logic [7:0]           pben;
        logic [7:0]           prescaler_assign_bit;
        logic [WDT_CNT_W-1:0] wdt;
        logic                 timeout_flag;
        logic                 powerdown_flag;
        logic                 gie;
        logic [7:0]           rdata;
        logic                 take;
        logic [11:0]          vec;
        logic                 wake;
        logic                 wdt_rst;
    } twis_regs_s;

    // Prescaler terminal value: Timer0 divides by 2^(ratio+1), watchdog by 2^ratio
    function automatic logic [7:0] psc_limit(input logic [2:0] ratio, input logic to_t0);
        logic [7:0] one;
        one = to_t0 ? 8'h02 : 8'h01;
        return (one << ratio) - 8'h01;
    endfunction

    logic       rst_s1_q;
    logic       rst_n;
    twis_regs_s q;
    twis_regs_s d;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    logic       psc_to_t0;
    logic       clk_rise;
    logic       clk_fall;
    logic       t0_src;
    logic       wdt_rise;
    logic       wdt_base_hit;
    logic       psc_event;
    logic       psc_hit;
    logic [7:0] psc_lim;
    logic       t0_tick;
    logic       wdt_timeout;
    logic       wr_count;
    logic       ext_edge;
    logic [7:0] pb_change;
    logic       pending;
    logic       running;

    // Edge and tick derivation from the second synchroniser stage only
    always_comb
    begin
        psc_to_t0    = ~q.mode[MODE_PSC_WDT];
        clk_rise     = q.sync2[PIN_T0_CLK] & ~q.prev[PIN_T0_CLK];
        clk_fall     = ~q.sync2[PIN_T0_CLK] & q.prev[PIN_T0_CLK];
        t0_src       = q.mode[MODE_CLK_SRC]
                     ? (q.mode[MODE_CLK_EDGE] ? clk_fall : clk_rise)
                     : 1'b1;
        wdt_rise     = q.sync2[PIN_WDT_OSC] & ~q.prev[PIN_WDT_OSC];
        wdt_base_hit = wdt_rise && (q.wdt == WDT_BASE - 1'b1);
        psc_event    = psc_to_t0 ? t0_src : wdt_base_hit;
        // Masked compare, so cutting the ratio below the running count still hits soon
        psc_lim      = psc_limit(q.mode[MODE_RATIO_HI -: 3], psc_to_t0);
        psc_hit      = psc_event && ((q.prescaler_assign_bit & psc_lim) == psc_lim);
        t0_tick      = psc_to_t0 ? psc_hit : t0_src;
        wdt_timeout  = psc_to_t0 ? wdt_base_hit : psc_hit;
        wr_count     = reg_we_i && (reg_addr_i == OFS_COUNT);
        ext_edge     = q.mode[MODE_EXT_EDGE]
                     ? (q.sync2[PIN_EXT_INT] & ~q.prev[PIN_EXT_INT])
                     : (~q.sync2[PIN_EXT_INT] & q.prev[PIN_EXT_INT]);
        // Output pins never raise a change, so driving them cannot self-trigger
        pb_change    = (q.sync2[7:0] ^ q.prev[7:0]) & q.pben & portb_is_input_i;
        pending      = |(q.flags & q.mask);
        running      = (q.st == TWIS_RUN);
    end

    // Next-state of the whole block
    always_comb
    begin
        d         = q;
        d.sync1   = {watchdog_osc_i, timer0_ext_clock_pin_i, ext_int_pin_i, portb_pin_i};
        d.sync2   = q.sync1;
        d.prev    = q.sync2;
        d.take    = 1'b0;
        d.wake    = 1'b0;
        d.wdt_rst = 1'b0;

        // Register writes; flag bits are cleared by writing 0 to them
        if (reg_we_i)
        begin
            unique case (reg_addr_i)
                OFS_MODE:  d.mode  = reg_wdata_i;
                OFS_FLAG:  d.flags = q.flags & reg_wdata_i[NUM_SRC-1:0];
                OFS_MASK:  d.mask  = reg_wdata_i[NUM_SRC-1:0];
                OFS_PBEN:  d.pben  = reg_wdata_i;
                default:   d.mode  = q.mode;
            endcase
        end

        // Timer0 counter; a write wins over the increment of the same cycle
        if (wr_count)
            d.count = reg_wdata_i;
        else if (t0_tick)
            d.count = q.count + 8'h01;

        // Prescaler and watchdog counters
        if (psc_event)
            d.prescaler_assign_bit = psc_hit ? 8'h00 : q.prescaler_assign_bit + 8'h01;
        if (wr_count && psc_to_t0)
            d.prescaler_assign_bit = 8'h00;
        if (wdt_rise)
            d.wdt = wdt_base_hit ? '0 : q.wdt + 1'b1;
        if (running && (watchdog_clear_instr_i || sleep_instr_i))
        begin
            d.wdt = '0;
            if (!psc_to_t0)
                d.prescaler_assign_bit = 8'h00;
            d.timeout_flag   = 1'b1;
            d.powerdown_flag = ~sleep_instr_i;
        end

        // Event flags; sets come after the register write so they win over a write clear
        if (t0_tick && !wr_count && q.count == 8'hFF)
            d.flags[SRC_T0] = 1'b1;
        if (timer1_wrap_i)
            d.flags[SRC_T1] = 1'b1;
        if (timer2_wrap_i)
            d.flags[SRC_T2] = 1'b1;
        if (ext_edge)
            d.flags[SRC_EXT] = 1'b1;
        // The change flag alone needs its mask bit to be set
        if ((|pb_change) && q.mask[SRC_PB])
            d.flags[SRC_PB] = 1'b1;
        if (wdt_timeout && !watchdog_action_select_i)
            d.flags[SRC_WDT] = 1'b1;

        // Global enable and vectoring
        if (running)
        begin
            if (global_int_enable_instr_i || return_from_isr_instr_i)
                d.gie = 1'b1;
            else if (global_int_disable_instr_i)
                d.gie = 1'b0;
            if (sw_int_instr_i)
            begin
                d.take = 1'b1;
                d.vec  = VEC_SWINT;
                d.gie  = 1'b0;
            end
            else if (q.gie && pending && !q.take)
            begin
                d.take = 1'b1;
                d.vec  = VEC_INT;
                d.gie  = 1'b0;
            end
            if (sleep_instr_i && !sw_int_instr_i)
                d.st = TWIS_SLEEP;
        end
        else if ((ext_edge && q.mask[SRC_EXT]) ||
                 ((|pb_change) && q.mask[SRC_PB]) ||
                 (wdt_timeout && !watchdog_action_select_i))
        begin
            // Wake leaves the enable untouched, so vectoring follows next cycle only if it was set
            d.st   = TWIS_RUN;
            d.wake = 1'b1;
        end

        // Reset-mode time-out reinitialises control state, powerdown kept
        if (wdt_timeout && watchdog_action_select_i)
        begin
            d.wdt_rst      = 1'b1;
            d.timeout_flag = 1'b0;
            d.st    = TWIS_RUN;
            d.mode  = RST_MODE;
            d.mask  = RST_MASK;
            d.pben  = RST_PBEN;
            d.flags = '0;
            d.gie   = 1'b0;
            d.take  = 1'b0;
            d.wdt   = '0;
            d.prescaler_assign_bit   = 8'h00;
        end

        // Read data valid in the cycle after the strobe
        d.rdata = 8'h00;
        if (reg_re_i)
        begin
            unique case (reg_addr_i)
                OFS_MODE:   d.rdata = q.mode;
                OFS_COUNT:  d.rdata = q.count;
                OFS_FLAG:   d.rdata = {2'b00, q.flags & q.mask};
                OFS_MASK:   d.rdata = {2'b00, q.mask};
                OFS_PBEN:   d.rdata = q.pben;
                OFS_STATUS: d.rdata = {3'b000, q.timeout_flag, q.powerdown_flag, 2'b00, q.gie};
                default:    d.rdata = 8'h00;
            endcase
        end
    end

    // State register; power-on leaves both status flags set
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q                <= '0;
            q.st             <= TWIS_RUN;
            q.mode           <= RST_MODE;
            q.pben           <= RST_PBEN;
            q.mask           <= RST_MASK;
            q.timeout_flag   <= 1'b1;
            q.powerdown_flag <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata_o  = q.rdata;
    assign int_take_o   = q.take;
    assign int_vector_o = q.vec;
    assign wake_o       = q.wake;
    assign wdt_reset_o  = q.wdt_rst;
    assign osc_stop_o   = (q.st == TWIS_SLEEP);
    assign io_hold_o    = (q.st == TWIS_SLEEP);

    // Checks of the block's own behaviour
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    a_t0_internal_count: assert property (
        (!q.mode[MODE_CLK_SRC] && q.mode[MODE_PSC_WDT] && !wr_count && !q.wdt_rst
         && !wdt_timeout) |=> (q.count == $past(q.count) + 8'h01))
        else $error("timer0 missed an internal tick");
    a_t0_ext_edge: assert property (
        (q.mode[MODE_CLK_SRC] && q.mode[MODE_PSC_WDT] && !wr_count && !wdt_timeout
         && (q.mode[MODE_CLK_EDGE] ? clk_fall : clk_rise)) |=> (q.count != $past(q.count)))
        else $error("timer0 missed an external edge");
    a_wdt_reset_out: assert property (
        (wdt_timeout && watchdog_action_select_i) |=> (wdt_reset_o && !q.timeout_flag))
        else $error("watchdog reset time-out not handled");
    a_psc_clear_write: assert property (
        (wr_count && psc_to_t0) |=> (q.prescaler_assign_bit == 8'h00))
        else $error("timer0 write did not clear prescaler");
    a_wdt_clear_instr: assert property (
        (running && watchdog_clear_instr_i && !wdt_timeout) |=> (q.wdt == '0 && q.timeout_flag))
        else $error("watchdog clear ignored");
    a_int_vector: assert property (
        (running && q.gie && pending && !q.take && !sw_int_instr_i && !wdt_timeout)
        |=> (int_take_o && int_vector_o == VEC_INT) ##1 !int_take_o)
        else $error("interrupt not vectored to 008h");
    a_swint_vector: assert property (
        (running && sw_int_instr_i && !wdt_timeout) |=> (int_take_o && int_vector_o == VEC_SWINT))
        else $error("software interrupt not vectored to 001h");
    a_flag_readback: assert property (
        (reg_re_i && reg_addr_i == OFS_FLAG)
        |=> (reg_rdata_o == {2'b00, $past(q.flags) & $past(q.mask)}))
        else $error("flag read is not masked");
    a_sleep_entry: assert property (
        (running && sleep_instr_i && !sw_int_instr_i && !wdt_timeout)
        |=> (osc_stop_o && io_hold_o && !q.powerdown_flag && q.timeout_flag))
        else $error("sleep entry incomplete");
    a_wdt_int_mode: assert property (
        (wdt_timeout && !watchdog_action_select_i) |=> (q.flags[SRC_WDT] && !wdt_reset_o))
        else $error("interrupt-mode time-out misbehaved");
    a_ext_int_flag: assert property (
        (ext_edge && !wdt_timeout) |=> q.flags[SRC_EXT])
        else $error("external edge did not set flag");

    // Flag, enable and wake checks; a reset-mode time-out overrides the three flag checks
    a_t0_wrap_flag: assert property (
        (t0_tick && !wr_count && q.count == 8'hFF && !wdt_timeout) |=> q.flags[SRC_T0])
        else $error("timer0 wrap did not set its flag");
    a_t1_flag_unmasked: assert property (
        (timer1_wrap_i && !q.mask[SRC_T1] && !wdt_timeout) |=> q.flags[SRC_T1])
        else $error("timer1 flag gated by its mask");
    a_pb_change_flag: assert property (
        ((|pb_change) && q.mask[SRC_PB] && !wdt_timeout) |=> q.flags[SRC_PB])
        else $error("port B change did not set flag");
    a_gie_disable: assert property (
        (running && global_int_disable_instr_i && !global_int_enable_instr_i
         && !return_from_isr_instr_i) |=> !q.gie)
        else $error("global disable ignored");
    a_wake_event: assert property (
        (!running && ext_edge && q.mask[SRC_EXT] && !wdt_timeout)
        |=> (wake_o && !osc_stop_o))
        else $error("enabled external edge did not wake");
    a_wake_resume: assert property (
        (wake_o && !q.gie && !sw_int_instr_i) |=> !int_take_o)
        else $error("wake without global enable vectored");

    c_int_taken:   cover property (int_take_o && int_vector_o == VEC_INT);
    c_wake_resume: cover property (wake_o && !q.gie);
    c_wdt_reset:   cover property (wdt_reset_o);
    c_t0_wrap:     cover property (q.flags[SRC_T0] && q.mode[MODE_CLK_SRC]);
    c_sw_vector:   cover property (int_take_o && int_vector_o == VEC_SWINT);

endmodule

// ### twis_cpu_model.sv
// Behavioural processor core: register port master and instruction pulses
`timescale 1ns/100ps
module twis_cpu_model
    import twis_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic [7:0]        reg_rdata_i,
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic      [7:0]        reg_wdata_o,
    output logic                   reg_we_o,
    output logic                   reg_re_o,
    output logic      [5:0]        instr_o
);
    // Lanes: 0 wdt clear, 1 enable, 2 disable, 3 return, 4 sw int, 5 sleep
    initial
    begin
        {reg_addr_o, reg_wdata_o, reg_we_o, reg_re_o, instr_o} = '0;
    end

    // Write: one strobe cycle, then the data bus stops showing the old value
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= v;
        reg_we_o    <= 1'b1;
        @(posedge ref_clk_i);
        reg_we_o    <= 1'b0;
        reg_wdata_o <= ~v;
    endtask

    // Read: data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_re_o   <= 1'b1;
        @(posedge ref_clk_i);
        reg_re_o   <= 1'b0;
        @(negedge ref_clk_i);
        v = reg_rdata_i;
    endtask

    // One instruction pulse on lane k
    task automatic op(input int k);
        @(posedge ref_clk_i);
        instr_o[k] <= 1'b1;
        @(posedge ref_clk_i);
        instr_o[k] <= 1'b0;
    endtask

    // Prescaler move in the safe order, so no stray watchdog reset fires
    task automatic move_psc(input logic [7:0] m);
        op(0);
        if (m[MODE_PSC_WDT])
            wr(OFS_COUNT, 8'h00);
        wr(OFS_MODE, m);
    endtask
endmodule

// ### tb_twis_core.sv
// Self-checking bench for the timer, watchdog, interrupt and sleep block
`timescale 1ns/100ps
`define CHK(n, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("[ERR] %s exp %0h got %0h", n, e, g); \
        end \
    end
module tb_twis_core
    import twis_pkg::*;
;
    typedef struct {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] e;} twis_row_s;
    logic              ref_clk = 1'b0, nrst = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wd, rdat, c0, c1, pb = 8'h00;
    logic [5:0]        ins;
    logic [11:0]       vec;
    logic              we, re, take, wake, wrst, ostop, hold;
    logic              t1w = 1'b0, t2w = 1'b0, act = 1'b1, wosc = 1'b0;
    logic              wdt_on = 1'b0, t0p = 1'b0, xp = 1'b0;
    int                compares = 0, fail_count = 0, wake_n = 0, rst_n = 0, cyc = 0;
    twis_row_s         rows[9] = '{
        '{1'b0, OFS_MODE, 8'h00, 8'h3F}, '{1'b0, OFS_MASK, 8'h00, 8'h00},
        '{1'b0, OFS_PBEN, 8'h00, 8'hFF}, '{1'b0, OFS_STATUS, 8'h00, 8'h18},
        '{1'b0, 3'h6, 8'h00, 8'h00}, '{1'b1, OFS_PBEN, 8'h0F, 8'h0F},
        '{1'b1, OFS_STATUS, 8'h55, 8'h18}, '{1'b1, OFS_MASK, 8'h3F, 8'h3F},
        '{1'b1, OFS_FLAG, 8'h00, 8'h00}};

    twis_cpu_model u_twis_cpu_model (.ref_clk_i(ref_clk), .reg_rdata_i(rdat),
        .reg_addr_o(addr), .reg_wdata_o(wd), .reg_we_o(we), .reg_re_o(re), .instr_o(ins));
    twis_core #(.WDT_BASE(WDT_CNT_W'(4))) u_twis_core (.ref_clk_i(ref_clk), .nrst_i(nrst),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdat), .watchdog_clear_instr_i(ins[0]),
        .global_int_enable_instr_i(ins[1]), .global_int_disable_instr_i(ins[2]),
        .return_from_isr_instr_i(ins[3]), .sw_int_instr_i(ins[4]), .sleep_instr_i(ins[5]),
        .timer1_wrap_i(t1w), .timer2_wrap_i(t2w), .watchdog_action_select_i(act),
        .watchdog_osc_i(wosc), .timer0_ext_clock_pin_i(t0p), .ext_int_pin_i(xp),
        .portb_pin_i(pb), .portb_is_input_i(8'hFE), .int_take_o(take),
        .int_vector_o(vec), .wake_o(wake), .wdt_reset_o(wrst), .osc_stop_o(ostop),
        .io_hold_o(hold));

    // Clock, slow watchdog oscillator that only runs when a test asks for it
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    always #50 wosc = wdt_on ? ~wosc : 1'b0;

    // Pulse counters and the hang limit, far above the roughly 1000 cycles used
    always @(posedge ref_clk)
    begin
        cyc++;
        wake_n += (wake === 1'b1);
        rst_n += (wrst === 1'b1);
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        u_twis_cpu_model.rd(a, v);
        `CHK(n, e, v)
    endtask
    task automatic w(input logic [2:0] a, input logic [7:0] v);
        u_twis_cpu_model.wr(a, v);
    endtask
    task automatic op(input int k);
        u_twis_cpu_model.op(k);
    endtask

    // Watches a bounded window for one take and its vector
    task automatic wait_take(input logic [11:0] v, input logic want, input string n);
        logic [12:0] got;
        got = '0;
        repeat (12)
        begin
            @(negedge ref_clk);
            if (take === 1'b1)
                got = {1'b1, vec};
        end
        `CHK(n, {want, want ? v : 12'h000}, got)
    endtask

    // Runs the watchdog until its reset pulse and checks the elapsed cycles
    task automatic wdt_run(input logic [7:0] m, input int lo, input int hi);
        int n;
        u_twis_cpu_model.move_psc(m);
        n = 0;
        rst_n = 0;
        wdt_on = 1'b1;
        while (rst_n == 0 && n < 300)
        begin
            @(posedge ref_clk);
            n++;
        end
        wdt_on = 1'b0;
        `CHK("wdt_period", 1'b1, n >= lo && n <= hi)
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Reset values, read-only status and writable registers
        foreach (rows[i])
        begin
            if (rows[i].w)
                w(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].e, "reg_row");
        end
        $display("test registers done");
        // Count rate per prescaler ratio, measured over exactly 32 cycles
        for (int r = 0; r < 4; r++)
        begin
            u_twis_cpu_model.move_psc(r == 3 ? 8'h08 : 8'(r));
            u_twis_cpu_model.rd(OFS_COUNT, c0);
            repeat (30) @(posedge ref_clk);
            u_twis_cpu_model.rd(OFS_COUNT, c1);
            `CHK("t0_rate", 8'(r == 3 ? 32 : 32 >> (r + 1)), 8'(c1 - c0))
        end
        u_twis_cpu_model.move_psc(8'h07);
        repeat (100) @(posedge ref_clk);
        w(OFS_COUNT, 8'h10);
        repeat (200) @(posedge ref_clk);
        rc(OFS_COUNT, 8'h10, "psc_clear");
        $display("test timer rate done");
        // Flags set with mask off, reads masked, then cleared
        u_twis_cpu_model.move_psc(8'h08);
        w(OFS_MASK, 8'h00);
        w(OFS_COUNT, 8'hFE);
        @(posedge ref_clk);
        {t1w, t2w} <= 2'b11;
        @(posedge ref_clk);
        {t1w, t2w} <= 2'b00;
        repeat (10) @(posedge ref_clk);
        rc(OFS_FLAG, 8'h00, "flag_masked");
        w(OFS_MODE, 8'h28);
        w(OFS_MASK, 8'h07);
        rc(OFS_FLAG, 8'h07, "flag_wraps");
        w(OFS_FLAG, 8'h00);
        w(OFS_MASK, 8'h08);
        pb <= 8'h81;
        repeat (10) @(posedge ref_clk);
        rc(OFS_FLAG, 8'h00, "pb_ignored");
        pb <= 8'h83;
        repeat (10) @(posedge ref_clk);
        rc(OFS_FLAG, 8'h08, "pb_change");
        $display("test flags done");
        // External clock: one edge direction counted per edge bit
        for (int e = 0; e < 2; e++)
        begin
            w(OFS_MODE, {3'b001, e[0], 4'h8});
            w(OFS_COUNT, 8'h00);
            t0p <= 1'b1;
            repeat (10) @(posedge ref_clk);
            rc(OFS_COUNT, {7'h00, ~e[0]}, "ext_rise");
            t0p <= 1'b0;
            repeat (10) @(posedge ref_clk);
            rc(OFS_COUNT, 8'h01, "ext_fall");
        end
        // Watchdog: base period, stretched period, then interrupt mode
        wdt_run(8'h20, 30, 50);
        rc(OFS_STATUS, 8'h08, "wdt_status");
        rc(OFS_MODE, 8'h3F, "wdt_mode");
        wdt_run(8'h29, 70, 90);
        act <= 1'b0;
        u_twis_cpu_model.move_psc(8'h20);
        w(OFS_MASK, 8'h20);
        wdt_on = 1'b1;
        repeat (100) @(posedge ref_clk);
        wdt_on = 1'b0;
        rc(OFS_FLAG, 8'h20, "wdt_int_flag");
        `CHK("wdt_no_reset", 1, rst_n)
        $display("test watchdog done");
        // Take, return, software vector, disabled global enable
        w(OFS_MASK, 8'h02);
        w(OFS_FLAG, 8'h00);
        op(1);
        t1w <= 1'b1;
        @(posedge ref_clk);
        t1w <= 1'b0;
        wait_take(VEC_INT, 1'b1, "take_008");
        w(OFS_FLAG, 8'h00);
        op(3);
        rc(OFS_STATUS, 8'h19, "gie_back");
        op(4);
        wait_take(VEC_SWINT, 1'b1, "take_001");
        op(2);
        t1w <= 1'b1;
        @(posedge ref_clk);
        t1w <= 1'b0;
        wait_take(VEC_INT, 1'b0, "no_take");
        $display("test interrupts done");
        // Sleep, then wake by the external pin with and without global enable
        w(OFS_MODE, 8'h68);
        w(OFS_MASK, 8'h10);
        w(OFS_FLAG, 8'h00);
        op(1);
        op(5);
        repeat (2) @(posedge ref_clk);
        `CHK("sleep_outs", 2'b11, {ostop, hold})
        rc(OFS_STATUS, 8'h11, "sleep_status");
        xp <= 1'b1;
        wait_take(VEC_INT, 1'b1, "wake_take");
        xp <= 1'b0;
        w(OFS_FLAG, 8'h00);
        op(5);
        repeat (2) @(posedge ref_clk);
        xp <= 1'b1;
        wait_take(VEC_INT, 1'b0, "wake_resume");
        `CHK("wake_count", 2, wake_n)
        `CHK("osc_back", 1'b0, ostop)
        $display("test sleep done");
        // Mid-run reset: mode and status flags return to power-on values
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rc(OFS_MODE, RST_MODE, "rst_mode");
        rc(OFS_STATUS, 8'h18, "rst_status");
        $display("test reset done");
        tally_and_finish();
    end
endmodule
